// >>> src/scf_cfg.svh
// Constants for the serial command front end (both ends).
// Assumes inclusion by bare name; no other dependency.
`ifndef SCF_CFG_SVH
`define SCF_CFG_SVH
`define SCF_CMD_BITS 16
`define SCF_DATA_BITS 16
`define SCF_ADDR_BITS 14
`define SCF_BIT_RW 15
`define SCF_BIT_REG 14
`define SCF_CNT_BITS 5
`define SCF_CNT_LAST 5'h0f
`define SCF_BYTE_MASK 5'h07
`define SCF_LINK_DIV 8'h03
`define SCF_GAP_CYC 8'h04
`endif

// >>> src/scf_pkg.sv
// Types for the serial command front end.
// Assumes scf_cfg.svh is on the include path.
`include "scf_cfg.svh"
package scf_pkg;
  typedef enum logic [1:0]
  {
    SCF_CMD = 2'h0,
    SCF_DATA = 2'h1
  } scf_phase_t;
  typedef enum logic [2:0]
  {
    SCF_H_IDLE = 3'h0,
    SCF_H_SEL = 3'h1,
    SCF_H_SHIFT = 3'h3,
    SCF_H_END = 3'h2,
    SCF_H_GAP = 3'h6
  } scf_host_t;
endpackage

// >>> src/scf_link_if.sv
// Five-pad serial link between host and device.
// Assumes pads resolved by the bench from enables.
`timescale 1ns/1ps
interface scf_link_if;
  logic sclk;
  logic csN;
  logic mosi;
  logic misoOut;
  logic misoOe;
  logic intrOut;
  modport dev
  (
    input sclk,
    input csN,
    input mosi,
    output misoOut,
    output misoOe,
    output intrOut
  );
  modport host
  (
    output sclk,
    output csN,
    output mosi,
    input misoOut,
    input misoOe,
    input intrOut
  );
endinterface

// >>> src/scf_device.sv
// Device end: command decoder, register port, buffer port.
// Assumes link clock from host; user side on ref_clk.
`timescale 1ns/1ps
`include "scf_cfg.svh"
module scf_device
(
  // User clock
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link pins
  scf_link_if.dev link,
  // Link-side reset, synchronous to sclk, active low
  input wire logic linkRst_n,
  // Strap: burst mode, latched but not used by the phase logic
  input wire logic burstMode,
  // Register port
  output logic regWrPulse,
  output logic regRdPulse,
  output logic [`SCF_ADDR_BITS-1:0] regAddr,
  output logic [`SCF_DATA_BITS-1:0] regWrData,
  input wire logic [`SCF_DATA_BITS-1:0] regRdData,
  // Buffer port
  output logic bufPushPulse,
  output logic bufPopPulse,
  output logic [`SCF_DATA_BITS-1:0] bufWrData,
  input wire logic [`SCF_DATA_BITS-1:0] bufRdData,
  // Interrupt request, level
  input wire logic intrReq
);
  logic [`SCF_CNT_BITS-1:0] cnt_reg;
  scf_pkg::scf_phase_t phase_reg;
  logic [`SCF_CMD_BITS-1:0] shift_reg;
  logic [`SCF_CMD_BITS-1:0] cmd_reg;
  logic [`SCF_DATA_BITS-1:0] out_reg;
  logic misoOut_reg;
  logic evTog_reg;
  logic rdTog_reg;
  logic strapMeta_reg;
  logic burstLatch_reg;
  logic misoOe_reg;
  logic [`SCF_DATA_BITS-1:0] loadWord;
  logic [`SCF_DATA_BITS-1:0] wrData_reg;
  logic [`SCF_CMD_BITS-1:0] shiftNext;
  logic cmdDone;
  logic dataDone;
  assign shiftNext = {shift_reg[`SCF_CMD_BITS-2:0], link.mosi};
  assign cmdDone = (phase_reg == scf_pkg::SCF_CMD) && (cnt_reg == `SCF_CNT_LAST);
  assign dataDone = (phase_reg == scf_pkg::SCF_DATA) && (cnt_reg == `SCF_CNT_LAST);
  assign loadWord = cmd_reg[`SCF_BIT_REG] ? regRdData : bufRdData;
  // Strap caught through two flops after reset release
  always_ff @(posedge link.sclk)
  begin
    if (!linkRst_n)
    begin
      strapMeta_reg <= 1'b0;
      burstLatch_reg <= 1'b0;
    end
    else
    begin
      strapMeta_reg <= burstMode;
      burstLatch_reg <= strapMeta_reg;
    end
  end
  // Bit count and phase, rising edge; select high resets both
  always_ff @(posedge link.sclk or posedge link.csN)
  begin
    if (link.csN)
    begin
      cnt_reg <= 5'h00;
      phase_reg <= scf_pkg::SCF_CMD;
    end
    else
    begin
      cnt_reg <= (cnt_reg == `SCF_CNT_LAST) ? 5'h00 : cnt_reg + 5'h01;
      if (cmdDone)
        phase_reg <= scf_pkg::SCF_DATA;
      else if (dataDone && cmd_reg[`SCF_BIT_REG])
        phase_reg <= scf_pkg::SCF_CMD;
    end
  end
  // Incoming bits, most significant first
  always_ff @(posedge link.sclk)
  begin
    if (!linkRst_n)
      shift_reg <= 16'h0000;
    else if (!link.csN)
      shift_reg <= shiftNext;
  end
  // Command capture at end of command phase
  always_ff @(posedge link.sclk)
  begin
    if (!linkRst_n)
      cmd_reg <= 16'h0000;
    else if (!link.csN && cmdDone)
      cmd_reg <= shiftNext;
  end
  // Read events: register read at command end, buffer pop after each word
  always_ff @(posedge link.sclk)
  begin
    if (!linkRst_n)
      rdTog_reg <= 1'b0;
    else if (!link.csN && cmdDone && shiftNext[`SCF_BIT_RW] && shiftNext[`SCF_BIT_REG])
      rdTog_reg <= ~rdTog_reg;
    else if (!link.csN && dataDone && cmd_reg[`SCF_BIT_RW] && !cmd_reg[`SCF_BIT_REG])
      rdTog_reg <= ~rdTog_reg;
  end
  // Write events after a whole data word
  always_ff @(posedge link.sclk)
  begin
    if (!linkRst_n)
    begin
      wrData_reg <= 16'h0000;
      evTog_reg <= 1'b0;
    end
    else if (!link.csN && dataDone && !cmd_reg[`SCF_BIT_RW])
    begin
      wrData_reg <= shiftNext;
      evTog_reg <= ~evTog_reg;
    end
  end
  // Output shift, falling edge
  always_ff @(negedge link.sclk)
  begin
    if (!linkRst_n)
    begin
      out_reg <= 16'h0000;
      misoOut_reg <= 1'b0;
    end
    else if (phase_reg == scf_pkg::SCF_DATA && cnt_reg == 5'h00)
    begin
      misoOut_reg <= loadWord[`SCF_DATA_BITS-1];
      out_reg <= {loadWord[`SCF_DATA_BITS-2:0], 1'b0};
    end
    else
    begin
      misoOut_reg <= out_reg[`SCF_DATA_BITS-1];
      out_reg <= {out_reg[`SCF_DATA_BITS-2:0], 1'b0};
    end
  end
  // Outgoing line driven only for read data, released on deselect
  always_ff @(negedge link.sclk or posedge link.csN)
  begin
    if (link.csN)
      misoOe_reg <= 1'b0;
    else
      misoOe_reg <= (phase_reg == scf_pkg::SCF_DATA) && cmd_reg[`SCF_BIT_RW];
  end
  assign link.misoOut = misoOut_reg;
  assign link.misoOe = misoOe_reg;
  // Crossing of events into ref_clk
  logic [2:0] evSync_reg;
  logic [2:0] rdSync_reg;
  logic intr_reg;
  logic evEdge;
  logic rdEdge;
  assign evEdge = evSync_reg[2] ^ evSync_reg[1];
  assign rdEdge = rdSync_reg[2] ^ rdSync_reg[1];
  // Toggle synchronisers into ref_clk
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      evSync_reg <= 3'h0;
      rdSync_reg <= 3'h0;
    end
    else
    begin
      evSync_reg <= {evSync_reg[1:0], evTog_reg};
      rdSync_reg <= {rdSync_reg[1:0], rdTog_reg};
    end
  end
  // One-cycle strobes per decoded event
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      regWrPulse <= 1'b0;
      regRdPulse <= 1'b0;
      bufPushPulse <= 1'b0;
      bufPopPulse <= 1'b0;
    end
    else
    begin
      regWrPulse <= evEdge && cmd_reg[`SCF_BIT_REG];
      bufPushPulse <= evEdge && !cmd_reg[`SCF_BIT_REG];
      regRdPulse <= rdEdge && cmd_reg[`SCF_BIT_REG];
      bufPopPulse <= rdEdge && !cmd_reg[`SCF_BIT_REG];
    end
  end
  // Address of the last decoded access
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      regAddr <= 14'h0000;
    else if (evEdge || rdEdge)
      regAddr <= cmd_reg[`SCF_ADDR_BITS-1:0];
  end
  // Write word, held stable by the toggle handshake
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      regWrData <= 16'h0000;
      bufWrData <= 16'h0000;
    end
    else if (evEdge)
    begin
      regWrData <= wrData_reg;
      bufWrData <= wrData_reg;
    end
  end
  // Interrupt level, same clock as its source
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      intr_reg <= 1'b0;
    else
      intr_reg <= intrReq;
  end
  assign link.intrOut = intr_reg;
endmodule

// >>> src/scf_host.sv
// Host end: issues one command and one data word per request.
// Assumes device end joined through scf_link_if.
`timescale 1ns/1ps
`include "scf_cfg.svh"
module scf_host
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link pins
  scf_link_if.host link,
  // Request
  input wire logic reqValid,
  input wire logic [`SCF_CMD_BITS-1:0] reqCmd,
  input wire logic [`SCF_DATA_BITS-1:0] reqData,
  output logic reqReady,
  // Answer
  output logic rspValid,
  output logic [`SCF_DATA_BITS-1:0] rspData,
  output logic intrPending
);
  scf_pkg::scf_host_t state_reg;
  logic [7:0] div_reg;
  logic [`SCF_CNT_BITS:0] bit_reg;
  logic [31:0] tx_reg;
  logic [`SCF_DATA_BITS-1:0] rx_reg;
  logic rd_reg;
  logic sclk_reg;
  logic cs_reg;
  logic mosi_reg;
  logic [1:0] misoSync_reg;
  logic [1:0] intrSync_reg;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      misoSync_reg <= 2'h0;
      intrSync_reg <= 2'h0;
      intrPending <= 1'b0;
    end
    else
    begin
      misoSync_reg <= {misoSync_reg[0], link.misoOut};
      intrSync_reg <= {intrSync_reg[0], link.intrOut};
      intrPending <= intrSync_reg[1];
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= scf_pkg::SCF_H_IDLE;
      div_reg <= 8'h00;
      bit_reg <= 6'h00;
      tx_reg <= 32'h0;
      rx_reg <= 16'h0000;
      rd_reg <= 1'b0;
      sclk_reg <= 1'b1;
      cs_reg <= 1'b1;
      mosi_reg <= 1'b0;
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= 16'h0000;
    end
    else
    begin
      rspValid <= 1'b0;
      case (state_reg)
        scf_pkg::SCF_H_IDLE:
        begin
          reqReady <= 1'b1;
          if (reqValid && reqReady)
          begin
            reqReady <= 1'b0;
            tx_reg <= {reqCmd, reqData};
            rd_reg <= reqCmd[`SCF_BIT_RW];
            cs_reg <= 1'b0;
            bit_reg <= 6'h00;
            div_reg <= 8'h00;
            state_reg <= scf_pkg::SCF_H_SEL;
          end
        end
        scf_pkg::SCF_H_SEL:
          state_reg <= scf_pkg::SCF_H_SHIFT;
        scf_pkg::SCF_H_SHIFT:
        begin
          if (div_reg == `SCF_LINK_DIV)
          begin
            div_reg <= 8'h00;
            sclk_reg <= ~sclk_reg;
            // Falling edge: present next bit
            if (sclk_reg)
            begin
              mosi_reg <= tx_reg[31];
              tx_reg <= {tx_reg[30:0], 1'b0};
            end
            // Rising edge: count and sample
            else
            begin
              bit_reg <= bit_reg + 6'h01;
              rx_reg <= {rx_reg[14:0], misoSync_reg[1]};
              if (bit_reg == 6'h1f)
                state_reg <= scf_pkg::SCF_H_END;
            end
          end
          else
            div_reg <= div_reg + 8'h01;
        end
        scf_pkg::SCF_H_END:
        begin
          cs_reg <= 1'b1;
          rspValid <= 1'b1;
          rspData <= rd_reg ? rx_reg : 16'h0000;
          div_reg <= 8'h00;
          state_reg <= scf_pkg::SCF_H_GAP;
        end
        scf_pkg::SCF_H_GAP:
        begin
          div_reg <= div_reg + 8'h01;
          if (div_reg == `SCF_GAP_CYC)
            state_reg <= scf_pkg::SCF_H_IDLE;
        end
        default:
          state_reg <= scf_pkg::SCF_H_IDLE;
      endcase
    end
  end
  assign link.sclk = sclk_reg;
  assign link.csN = cs_reg;
  assign link.mosi = mosi_reg;
endmodule

// >>> bench/scf_link_checker.sv
// Checker for the five-pad link between host and device ends.
// Assumes instantiation beside scf_link_if in the bench top.
`timescale 1ns/1ps
module scf_link_checker
(
  // Clocks and resets
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic linkRst_n,
  // Link signals
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic misoOut,
  input wire logic misoOe,
  input wire logic intrOut
);
  logic [5:0] edgeCnt;
  logic cmdTop;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !linkRst_n);
  // Rising clock edges within one select window
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || csN)
      edgeCnt <= 6'h00;
    else if ($rose(sclk))
      edgeCnt <= edgeCnt + 6'h01;
  end
  // First command bit seen on the wire
  always_ff @(posedge ref_clk)
  begin
    if ($rose(sclk) && !csN && edgeCnt == 6'h00)
      cmdTop <= mosi;
  end
  chk_sclk_idle_high: assert property ($fell(csN) |-> sclk && $past(sclk))
    else $error("clock not high at select");
  chk_miso_released: assert property (csN && $past(csN) && $past(csN, 2) |-> !misoOe)
    else $error("miso driven while deselected");
  chk_miso_on_fall: assert property (misoOe && $past(misoOe) && $changed(misoOut) |-> $fell(sclk))
    else $error("miso changed off falling edge");
  chk_mosi_at_rise: assert property (!csN && $rose(sclk) |-> $stable(mosi))
    else $error("mosi changed at rising edge");
  chk_frame_length: assert property ($rose(csN) |-> edgeCnt == 6'h20)
    else $error("frame is not thirty-two bits");
  chk_miso_read_only: assert property (!csN && misoOe |-> cmdTop && edgeCnt >= 6'h10)
    else $error("miso driven outside read data");
  chk_select_held: assert property ($fell(csN) |-> ##[250:266] $rose(csN))
    else $error("select window length wrong");
  chk_select_gap: assert property ($rose(csN) |-> csN [*5])
    else $error("second transfer too close");
endmodule

// >>> bench/spi_slave_command_frontend_bench.sv
// Bench for the serial command front end, both ends joined.
// Assumes src files compiled first; ref_clk period 25 ns.
`timescale 1ns/1ps
module spi_slave_command_frontend_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic linkRst_n = 1'b0;
  logic reqValid = 1'b0;
  logic [15:0] reqCmd = 16'h0000;
  logic [15:0] reqData = 16'h0000;
  logic [15:0] regRdData = 16'h0000;
  logic [15:0] bufRdData = 16'h0000;
  logic intrReq = 1'b0;
  logic burstMode = 1'b0;
  logic reqReady, rspValid, intrPending, regWrPulse, regRdPulse, bufPushPulse, bufPopPulse;
  logic [15:0] rspData, regWrData, bufWrData, seenD;
  logic [13:0] regAddr, seenA;
  int wrN, rdN, pushN, popN, compares, badCount, cycles;
  always #12.5 ref_clk = ~ref_clk;
  scf_link_if link();
  scf_host u_scf_host (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .reqValid(reqValid),
    .reqCmd(reqCmd), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .intrPending(intrPending));
  scf_device u_scf_device (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .linkRst_n(linkRst_n), .burstMode(burstMode), .regWrPulse(regWrPulse),
    .regRdPulse(regRdPulse), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .bufPushPulse(bufPushPulse), .bufPopPulse(bufPopPulse),
    .bufWrData(bufWrData), .bufRdData(bufRdData), .intrReq(intrReq));
  scf_link_checker u_scf_link_checker (.ref_clk(ref_clk), .rst_n(rst_n),
    .linkRst_n(linkRst_n), .sclk(link.sclk), .csN(link.csN), .mosi(link.mosi),
    .misoOut(link.misoOut), .misoOe(link.misoOe), .intrOut(link.intrOut));
  // Device-side pulse monitor
  always @(negedge ref_clk)
  begin
    if (regWrPulse === 1'b1 || bufPushPulse === 1'b1)
      seenD = (regWrPulse === 1'b1) ? regWrData : bufWrData;
    if (regWrPulse === 1'b1 || regRdPulse === 1'b1)
      seenA = regAddr;
    wrN += int'(regWrPulse === 1'b1);
    rdN += int'(regRdPulse === 1'b1);
    pushN += int'(bufPushPulse === 1'b1);
    popN += int'(bufPopPulse === 1'b1);
  end
  task automatic finishTest();
    if (badCount == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want)
    begin
      badCount++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // One whole transaction through the host end
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] data);
    int n;
    n = 0;
    wrN = 0;
    rdN = 0;
    pushN = 0;
    popN = 0;
    seenA = 'x;
    seenD = 'x;
    @(negedge ref_clk);
    reqValid = 1'b1;
    reqCmd = cmd;
    reqData = data;
    while (reqReady !== 1'b1 && n < 100)
    begin
      @(negedge ref_clk);
      n++;
    end
    check({15'h0000, reqReady}, 16'h0001);
    @(negedge ref_clk);
    reqValid = 1'b0;
    check({15'h0000, reqReady}, 16'h0000);
    while (rspValid !== 1'b1 && n < 400)
    begin
      @(negedge ref_clk);
      n++;
    end
    check({15'h0000, rspValid}, 16'h0001);
    repeat (20) @(negedge ref_clk);
  endtask
  task automatic regWriteTest();
    xfer({1'b0, 1'b1, 14'h3fff}, 16'hc3a5);
    check(16'(wrN), 16'h0001);
    check({2'h0, seenA}, 16'h3fff);
    check(seenD, 16'hc3a5);
    check(16'(pushN), 16'h0000);
  endtask
  task automatic regReadTest();
    regRdData = 16'h8421;
    xfer({1'b1, 1'b1, 14'h0001}, 16'hffff);
    check(rspData, 16'h8421);
    check(16'(rdN), 16'h0001);
    check({2'h0, seenA}, 16'h0001);
    check(16'(wrN), 16'h0000);
  endtask
  task automatic bufWriteTest();
    xfer({1'b0, 1'b0, 14'h1234}, 16'h5aa5);
    check(16'(pushN), 16'h0001);
    check(seenD, 16'h5aa5);
    check(16'(wrN), 16'h0000);
  endtask
  task automatic bufReadTest();
    bufRdData = 16'h0ff0;
    xfer({1'b1, 1'b0, 14'h2aaa}, 16'h0000);
    check(rspData, 16'h0ff0);
    check(16'(popN), 16'h0001);
    check(16'(rdN), 16'h0000);
  endtask
  task automatic intrTest();
    intrReq = 1'b1;
    repeat (10) @(negedge ref_clk);
    check({15'h0000, intrPending}, 16'h0001);
    intrReq = 1'b0;
    repeat (10) @(negedge ref_clk);
    check({15'h0000, intrPending}, 16'h0000);
  endtask
  // Cut a hang short
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      badCount++;
      finishTest();
    end
  end
  initial
  begin
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    xfer(16'h0000, 16'h0000);
    linkRst_n = 1'b1;
    regWriteTest();
    regReadTest();
    bufWriteTest();
    bufReadTest();
    intrTest();
    finishTest();
  end
endmodule
